// ---- logic/iesc_consts.svh ----
// Constants of the interrupt enable-set and tick calibration register block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef IESC_CONSTS_SVH
`define IESC_CONSTS_SVH

// =====================================================================
// Register offsets (byte addresses within the block)
`define IESC_OFS_CALIB        12'h010
`define IESC_OFS_ENABLE_SET   12'h100
`define IESC_ADDR_W           12

// =====================================================================
// Calibration word fields
`define IESC_CAL_NO_REF_CLOCK_FLAG_BIT    31
`define IESC_CAL_INEXACT_BIT  30
`define IESC_CAL_RSVD_HI      29
`define IESC_CAL_RSVD_LO      24
`define IESC_CAL_COUNT_HI     23
`define IESC_CAL_COUNT_LO     0
`define IESC_CAL_COUNT_RST    24'h0009c4
`define IESC_CAL_NO_REF_CLOCK_FLAG_RST    1'h0
`define IESC_CAL_INEXACT_RST  1'h0

// =====================================================================
// Enable register
`define IESC_ENABLE_RST       32'h0000_0000
`define IESC_NUM_IRQ          32

`endif

// ---- logic/iesc_pkg.sv ----
// Types shared by the enable-set and calibration register block.
// Assumes the constants header is on the include path.
`include "iesc_consts.svh"

package iesc_pkg;

	// =================================================================
	// Captured AHB-Lite address phase
	typedef struct packed {
		logic                      valid;
		logic                      wr;
		logic [`IESC_ADDR_W-1:0]   addr;
	} iesc_aphase_t;

	// =================================================================
	// Calibration word layout
	typedef struct packed {
		logic        no_ref_clock_flag;
		logic        calib_inexact_flag;
		logic [5:0]  rsvd;
		logic [23:0] calibration_count;
	} iesc_calib_t;

endpackage

// ---- logic/iesc_enable_bit.sv ----
// One interrupt enable flip-flop with set and clear terms.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
`include "iesc_consts.svh"

module iesc_enable_bit (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset_n,
	// Control
	input  wire logic set_en,
	input  wire logic clr_en,
	// State
	output logic      en_nxt,
	output logic      en_r
);

	// =================================================================
	// Next state: set wins over clear, zero write keeps state
	always_comb begin
		en_nxt = (en_r & ~clr_en) | set_en;
	end

	// =================================================================
	// Register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			en_r <= 1'h0;
		end else begin
			en_r <= en_nxt;
		end
	end

endmodule

// ---- logic/iesc_regs.sv ----
// AHB-Lite register block: tick calibration word and interrupt set-enable.
// Assumes one AHB-Lite master, single word transfers, clear requests from
// a neighbouring block on the same clock.
`timescale 1ns/1ps
`include "iesc_consts.svh"

module iesc_regs #(
	parameter int          NUM_IRQ     = `IESC_NUM_IRQ,
	parameter logic        NO_REF      = `IESC_CAL_NO_REF_CLOCK_FLAG_RST,
	parameter logic        INEXACT     = `IESC_CAL_INEXACT_RST,
	parameter logic [23:0] CALIB_COUNT = `IESC_CAL_COUNT_RST
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Interrupt enables
	input  wire logic [31:0] irq_enable_clear,
	output logic [31:0]      irq_enable_set_bits
);

	// =================================================================
	// Signals
	iesc_pkg::iesc_aphase_t aph_r;
	iesc_pkg::iesc_aphase_t aph_nxt;
	iesc_pkg::iesc_calib_t  calib_word;
	logic [31:0]            hrdata_r;
	logic [31:0]            hrdata_nxt;
	logic [31:0]            en_nxt;
	logic [31:0]            en_r;
	logic [31:0]            set_vec;
	logic                   wr_en_phase;
	logic                   aph_take;

	// =================================================================
	// Fixed calibration word
	always_comb begin
		calib_word.no_ref_clock_flag  = NO_REF;
		calib_word.calib_inexact_flag = INEXACT;
		calib_word.rsvd               = 6'h00;
		calib_word.calibration_count  = CALIB_COUNT;
	end

	// =================================================================
	// Address phase capture
	always_comb begin
		aph_take      = hsel & htrans[1] & hready;
		aph_nxt       = aph_r;
		aph_nxt.valid = 1'h0;
		if (hready) begin
			aph_nxt.valid = aph_take;
			aph_nxt.wr    = hwrite;
			aph_nxt.addr  = haddr[`IESC_ADDR_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			aph_r <= '0;
		end else begin
			aph_r <= aph_nxt;
		end
	end

	// =================================================================
	// Set-enable bits, one flop per interrupt
	always_comb begin
		wr_en_phase = aph_r.valid & aph_r.wr &
			(aph_r.addr == `IESC_OFS_ENABLE_SET);
		set_vec     = wr_en_phase ? hwdata : 32'h0000_0000;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IRQ; gi++) begin : g_en
			// Bit gi of the word drives interrupt gi
			iesc_enable_bit u_bit (
				.clk_sys (clk_sys),
				.reset_n (reset_n),
				.set_en  (set_vec[gi]),
				.clr_en  (irq_enable_clear[gi]),
				.en_nxt  (en_nxt[gi]),
				.en_r    (en_r[gi])
			);
		end
		for (gi = NUM_IRQ; gi < 32; gi++) begin : g_unused
			assign en_nxt[gi] = 1'h0;
			assign en_r[gi]   = 1'h0;
		end
	endgenerate

	assign irq_enable_set_bits = en_r;

	// =================================================================
	// Read data, forwarded from next enable state
	always_comb begin
		hrdata_nxt = 32'h0000_0000;
		if (aph_take && !hwrite) begin
			unique case (haddr[`IESC_ADDR_W-1:0])
				`IESC_OFS_CALIB: begin
					hrdata_nxt = calib_word;
				end
				`IESC_OFS_ENABLE_SET: begin
					hrdata_nxt = en_nxt;
				end
				default: begin
					hrdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hrdata_r <= 32'h0000_0000;
		end else begin
			hrdata_r <= hrdata_nxt;
		end
	end

	assign hrdata    = hrdata_r;
	assign hreadyout = 1'h1;
	assign hresp     = 1'h0;

	// =================================================================
	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	sequence s_rd_calib;
		aph_r.valid && !aph_r.wr && aph_r.addr == `IESC_OFS_CALIB;
	endsequence

	sequence s_rd_enable;
		aph_r.valid && !aph_r.wr && aph_r.addr == `IESC_OFS_ENABLE_SET;
	endsequence

	sequence s_wr_enable;
		aph_r.valid && aph_r.wr && aph_r.addr == `IESC_OFS_ENABLE_SET;
	endsequence

	sequence s_rd_enable_req;
		hsel && htrans[1] && hready && !hwrite &&
			haddr[`IESC_ADDR_W-1:0] == `IESC_OFS_ENABLE_SET;
	endsequence

	no_ref_clock_flag_bit_a: assert property (
		s_rd_calib |-> hrdata[31] == NO_REF)
		else $error("calibration bit 31 wrong");

	inexact_bit_a: assert property (
		s_rd_calib |-> hrdata[30] == INEXACT)
		else $error("calibration bit 30 wrong");

	calib_count_a: assert property (
		s_rd_calib |-> hrdata[23:0] == CALIB_COUNT)
		else $error("calibration count wrong");

	calib_fixed_a: assert property (
		s_rd_calib |-> hrdata[29:24] == 6'h00 &&
			hrdata == {NO_REF, INEXACT, 6'h00, CALIB_COUNT})
		else $error("calibration word changed or reserved set");

	bit_map_a: assert property (
		s_wr_enable |=> irq_enable_set_bits ==
			(($past(irq_enable_set_bits) & ~$past(irq_enable_clear))
			| $past(hwdata)))
		else $error("enable bit mapping wrong");

	write_one_a: assert property (
		s_wr_enable ##1 1'b1 |->
			(irq_enable_set_bits & $past(hwdata)) == $past(hwdata))
		else $error("written one did not enable");

	write_zero_a: assert property (
		(!wr_en_phase && irq_enable_clear == 32'h0000_0000) |=>
			$stable(irq_enable_set_bits))
		else $error("enable changed without a set");

	read_state_a: assert property (
		s_rd_enable_req ##1 s_rd_enable |-> hrdata == irq_enable_set_bits)
		else $error("enable read mismatch");

	zero_wait_a: assert property (
		(!aph_r.valid || aph_r.wr) |->
			hrdata == 32'h0000_0000 && hreadyout && !hresp)
		else $error("idle read data or response wrong");

endmodule

// ---- test/iesc_regs_bench.sv ----
// Testbench for the enable-set and tick calibration register block.
// Assumes a single AHB-Lite master (this bench) with hready fed back.
`timescale 1ns/1ps
`include "iesc_consts.svh"

module iesc_regs_bench;

	// =================================================================
	// Signals
	logic        clk_sys;
	logic        reset_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [31:0] irq_enable_clear;
	logic [31:0] irq_enable_set_bits;
	logic [31:0] rd;
	logic [31:0] exp_en;
	int          num_errors;
	int          checks_done;
	int          n;

	iesc_regs iesc_regs_inst (
		.clk_sys             (clk_sys),
		.reset_n             (reset_n),
		.hsel                (hsel),
		.haddr               (haddr),
		.htrans              (htrans),
		.hwrite              (hwrite),
		.hsize               (hsize),
		.hwdata              (hwdata),
		.hready              (hreadyout),
		.hreadyout           (hreadyout),
		.hresp               (hresp),
		.hrdata              (hrdata),
		.irq_enable_clear    (irq_enable_clear),
		.irq_enable_set_bits (irq_enable_set_bits)
	);

	always #12.5 clk_sys = ~clk_sys;

	// =================================================================
	// Tasks
	task automatic chk(input logic [31:0] got, exp, input string what);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic xfer(input logic wr, input logic [31:0] addr, wd,
		output logic [31:0] rdv);
		hsel <= 1'b1;
		haddr <= addr;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// =================================================================
	// Watchdog
	initial begin
		#(3000 * 25);
		num_errors++;
		close_out;
	end

	// =================================================================
	// Tests
	initial begin
		clk_sys = 1'b0;
		reset_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		irq_enable_clear = 32'h0000_0000;
		num_errors = 0;
		checks_done = 0;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		xfer(1'b0, `IESC_OFS_CALIB, 32'h0, rd);
		chk({31'h0, rd[31]}, 32'h0, "no ref flag");
		chk({31'h0, rd[30]}, 32'h0, "inexact flag");
		chk({8'h00, rd[23:0]}, 32'h0000_09c4, "calib count");
		chk({26'h0, rd[29:24]}, 32'h0, "calib reserved");
		xfer(1'b0, `IESC_OFS_ENABLE_SET, 32'h0, rd);
		chk(rd, 32'h0000_0000, "enable reset");
		$display("test reset_values done");
		xfer(1'b1, `IESC_OFS_CALIB, 32'hffff_ffff, rd);
		xfer(1'b0, `IESC_OFS_CALIB, 32'h0, rd);
		chk(rd, 32'h0000_09c4, "calib after write");
		$display("test calib_read_only done");
		exp_en = 32'h0000_0000;
		for (n = 0; n < 32; n++) begin
			xfer(1'b1, `IESC_OFS_ENABLE_SET, 32'h1 << n, rd);
			exp_en = exp_en | (32'h1 << n);
			xfer(1'b0, `IESC_OFS_ENABLE_SET, 32'h0, rd);
			chk(rd, exp_en, "enable read");
			@(negedge clk_sys);
			chk(irq_enable_set_bits, exp_en, "en bits");
			@(posedge clk_sys);
		end
		$display("test walking_set done");
		irq_enable_clear <= 32'h8000_0001;
		@(posedge clk_sys);
		irq_enable_clear <= 32'h0000_0000;
		exp_en = 32'h7fff_fffe;
		xfer(1'b1, `IESC_OFS_ENABLE_SET, 32'h0000_0000, rd);
		xfer(1'b0, `IESC_OFS_ENABLE_SET, 32'h0, rd);
		chk(rd, exp_en, "zero write");
		xfer(1'b1, `IESC_OFS_ENABLE_SET, 32'h0000_0001, rd);
		xfer(1'b0, `IESC_OFS_ENABLE_SET, 32'h0, rd);
		chk(rd, 32'h7fff_ffff, "partial set");
		irq_enable_clear <= 32'h0000_0003;
		xfer(1'b1, `IESC_OFS_ENABLE_SET, 32'h0000_0001, rd);
		irq_enable_clear <= 32'h0000_0000;
		xfer(1'b0, `IESC_OFS_ENABLE_SET, 32'h0, rd);
		chk(rd, 32'h7fff_fffd, "set beats clear");
		$display("test zero_write done");
		xfer(1'b1, 32'h0000_0200, 32'hffff_ffff, rd);
		xfer(1'b0, 32'h0000_0200, 32'h0, rd);
		chk(rd, 32'h0000_0000, "unmapped");
		chk(irq_enable_set_bits, 32'h7fff_fffd, "after unmapped");
		chk({31'h0, hresp}, 32'h0000_0000, "response");
		$display("test unmapped done");
		close_out;
	end

endmodule
